//--- inc/ps2rp_pkg.sv
// Constants shared by the PS/2 receive port: register addresses, field
// positions and link timing counts.
// Assumes a 200 MHz system clock (5 ns period).
package ps2rp_pkg;
    // ------------------------------------------------------------------
    // Clock and link timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 5000;
    // Host holds the link clock low this long before sending a command
    localparam int unsigned INHIBIT_TIME_NS = 100000;
    localparam int unsigned INHIBIT_CYCLES =
        (INHIBIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Longest silence tolerated inside a frame, in either direction
    localparam int unsigned TIMEOUT_TIME_US = 2000;
    localparam int unsigned TIMEOUT_CYCLES =
        TIMEOUT_TIME_US * 1000000 / CLK_PERIOD_PS;

    // ------------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------------
    localparam logic [31:0] DATA_ADDR = 32'h10000100;
    localparam logic [31:0] CONTROL_ADDR = 32'h10000104;
    localparam int unsigned VALID_BIT = 15;
    localparam int unsigned COUNT_LSB = 16;
    localparam int unsigned IRQ_EN_BIT = 0;
    localparam int unsigned IRQ_PEND_BIT = 8;
    localparam int unsigned CE_BIT = 10;
    localparam logic IRQ_EN_RESET = 1'b0;
    localparam logic CE_RESET = 1'b0;
    localparam int unsigned FIFO_DEPTH = 256;
    localparam int unsigned FRAME_BITS = 11;

    // Transmit sequencer states
    typedef enum logic [2:0] {
        PS2RP_TX_IDLE = 3'b001,
        PS2RP_TX_INHIBIT = 3'b010,
        PS2RP_TX_SEND = 3'b100
    } ps2rp_tx_state_t;
endpackage : ps2rp_pkg

//--- design/ps2rp_port.sv
// PS/2 host port: receive queue, command transmitter and two registers.
// Assumes a single processor port with one-cycle read data and open-drain
// PS/2 clock and data pins resolved outside this module.
`timescale 1ns/100ps

// Summary of operation
// - Queue received bytes in 256-entry FIFO.
// - Data register bit 15 valid, oldest byte.
// - Valid read reports count including delivered entry.
// - Data byte written while idle transmitted as device command.
// - Enabled interrupt asserted while count above zero.
// - Pending flag follows interrupt, clears when empty.
// - Command error flag set on transmit failure.
module ps2rp_port #(
    parameter int unsigned DEPTH = ps2rp_pkg::FIFO_DEPTH,
    parameter int unsigned INHIBIT_CYCLES = ps2rp_pkg::INHIBIT_CYCLES,
    parameter int unsigned TIMEOUT_CYCLES = ps2rp_pkg::TIMEOUT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [31:0] bus_addr,
    input wire logic bus_read,
    input wire logic bus_write,
    input wire logic [31:0] bus_wdata,
    output logic [31:0] bus_rdata,
    output logic bus_rvalid,
    output logic irq,
    input wire logic ps2_clk_in,
    output logic ps2_clk_out,
    output logic ps2_clk_oe,
    input wire logic ps2_dat_in,
    output logic ps2_dat_out,
    output logic ps2_dat_oe
);
    localparam int AW = $clog2(DEPTH);
    localparam int TW = $clog2(TIMEOUT_CYCLES + INHIBIT_CYCLES + 1);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    if (DEPTH < 2 || DEPTH > 65535 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two between 2 and 32768");
    end
    if (INHIBIT_CYCLES < 1 || TIMEOUT_CYCLES < 1) begin : g_bad_time
        $error("Timing counts must be at least one cycle");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [2:0] clk_sync;
    logic [2:0] dat_sync;
    logic clk_lvl;
    logic dat_lvl;
    logic clk_lvl_d;
    logic clk_fall;

    // Three stages; a level counts only once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            clk_sync <= 3'h7;
            dat_sync <= 3'h7;
        end else begin
            clk_sync <= {clk_sync[1:0], ps2_clk_in};
            dat_sync <= {dat_sync[1:0], ps2_dat_in};
        end
    end

    // Filtered levels, plus one delayed copy of the clock for edges
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            clk_lvl <= 1'b1;
            dat_lvl <= 1'b1;
            clk_lvl_d <= 1'b1;
        end else begin
            if (clk_sync[1] == clk_sync[2]) begin
                clk_lvl <= clk_sync[2];
            end
            if (dat_sync[1] == dat_sync[2]) begin
                dat_lvl <= dat_sync[2];
            end
            clk_lvl_d <= clk_lvl;
        end
    end

    assign clk_fall = clk_lvl_d & ~clk_lvl;

    // ------------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------------
    logic [AW:0] count;
    logic data_rd;
    logic data_wr;
    logic ctrl_wr;
    logic pop;
    logic push;
    logic [7:0] rx_byte;

    assign data_rd = bus_read && bus_addr == ps2rp_pkg::DATA_ADDR;
    assign data_wr = bus_write && bus_addr == ps2rp_pkg::DATA_ADDR;
    assign ctrl_wr = bus_write && bus_addr == ps2rp_pkg::CONTROL_ADDR;
    assign pop = data_rd && count != '0;

    // ------------------------------------------------------------------
    // Receive queue
    // ------------------------------------------------------------------
    logic [7:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;

    // Storage array; a byte arriving while full is dropped
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= rx_byte;
        end
    end

    // Pointers and occupancy move together
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // ------------------------------------------------------------------
    // Receive framing
    // ------------------------------------------------------------------
    ps2rp_pkg::ps2rp_tx_state_t tx_state;
    logic [9:0] rx_shift;
    logic [3:0] rx_bits;
    logic [TW-1:0] rx_idle;
    logic [10:0] frame;
    logic frame_ok;

    assign frame = {dat_lvl, rx_shift};
    // Start low, odd parity over data and parity, stop high
    assign frame_ok = !frame[0] && frame[10] && (^frame[9:1]);
    assign rx_byte = frame[8:1];
    assign push = clk_fall && tx_state == ps2rp_pkg::PS2RP_TX_IDLE &&
        rx_bits == 4'(ps2rp_pkg::FRAME_BITS - 1) && frame_ok &&
        count != (AW+1)'(DEPTH);

    // Bits are taken on falling link clock edges, LSB first; a stalled
    // frame is abandoned so a glitch cannot misalign every later byte
    always_ff @(posedge ref_clk) begin
        if (srst || tx_state != ps2rp_pkg::PS2RP_TX_IDLE) begin
            rx_shift <= '0;
            rx_bits <= '0;
            rx_idle <= '0;
        end else if (clk_fall) begin
            rx_shift <= {dat_lvl, rx_shift[9:1]};
            rx_idle <= '0;
            if (rx_bits == 4'(ps2rp_pkg::FRAME_BITS - 1)) begin
                rx_bits <= '0;
            end else begin
                rx_bits <= rx_bits + 1'b1;
            end
        end else if (rx_bits != '0) begin
            if (rx_idle == TW'(TIMEOUT_CYCLES - 1)) begin
                rx_bits <= '0;
                rx_idle <= '0;
            end else begin
                rx_idle <= rx_idle + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Command transmitter
    // ------------------------------------------------------------------
    logic [8:0] tx_shift;
    logic [3:0] tx_bits;
    logic [TW-1:0] tx_timer;
    logic tx_error;
    logic tx_timeout;

    assign tx_timeout = tx_timer == TW'(TIMEOUT_CYCLES - 1);

    // Inhibit the link, request to send, then drive one bit per falling
    // edge; writes while busy are ignored so a command is never torn
    always_ff @(posedge ref_clk) begin
        tx_error <= 1'b0;
        if (srst) begin
            tx_state <= ps2rp_pkg::PS2RP_TX_IDLE;
            tx_shift <= '0;
            tx_bits <= '0;
            tx_timer <= '0;
            ps2_clk_oe <= 1'b0;
            ps2_dat_oe <= 1'b0;
        end else begin
            unique case (tx_state)
                ps2rp_pkg::PS2RP_TX_IDLE: begin
                    if (data_wr) begin
                        tx_shift <= {~^bus_wdata[7:0],
                            bus_wdata[7:0]};
                        tx_timer <= '0;
                        ps2_clk_oe <= 1'b1;
                        tx_state <= ps2rp_pkg::PS2RP_TX_INHIBIT;
                    end
                end
                ps2rp_pkg::PS2RP_TX_INHIBIT: begin
                    tx_timer <= tx_timer + 1'b1;
                    if (tx_timer == TW'(INHIBIT_CYCLES - 1)) begin
                        ps2_clk_oe <= 1'b0;
                        ps2_dat_oe <= 1'b1; // Start bit
                        tx_bits <= '0;
                        tx_timer <= '0;
                        tx_state <= ps2rp_pkg::PS2RP_TX_SEND;
                    end
                end
                ps2rp_pkg::PS2RP_TX_SEND: begin
                    tx_timer <= tx_timer + 1'b1;
                    if (clk_fall) begin
                        tx_bits <= tx_bits + 1'b1;
                        tx_timer <= '0;
                        if (tx_bits < 4'h9) begin
                            ps2_dat_oe <= ~tx_shift[0];
                            tx_shift <= {1'b1, tx_shift[8:1]};
                        end else if (tx_bits == 4'h9) begin
                            ps2_dat_oe <= 1'b0; // Stop bit
                        end else begin
                            tx_error <= dat_lvl;
                            tx_state <= ps2rp_pkg::PS2RP_TX_IDLE;
                        end
                    end else if (tx_timeout) begin
                        tx_error <= 1'b1;
                        ps2_dat_oe <= 1'b0;
                        tx_state <= ps2rp_pkg::PS2RP_TX_IDLE;
                    end
                end
            endcase
        end
    end

    assign ps2_clk_out = 1'b0;
    assign ps2_dat_out = 1'b0;

    // ------------------------------------------------------------------
    // Control register and interrupt
    // ------------------------------------------------------------------
    logic rx_irq_enable;
    logic cmd_error;
    logic rx_irq_pending;

    // Error is write-one-to-clear; a new error in the same cycle wins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rx_irq_enable <= ps2rp_pkg::IRQ_EN_RESET;
            cmd_error <= ps2rp_pkg::CE_RESET;
        end else begin
            if (ctrl_wr) begin
                rx_irq_enable <= bus_wdata[ps2rp_pkg::IRQ_EN_BIT];
            end
            if (tx_error) begin
                cmd_error <= 1'b1;
            end else if (ctrl_wr && bus_wdata[ps2rp_pkg::CE_BIT]) begin
                cmd_error <= 1'b0;
            end
        end
    end

    // Pending drops when the queue has been drained or the interrupt is disabled
    assign rx_irq_pending = rx_irq_enable && count != '0;
    assign irq = rx_irq_pending;

    // ------------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------------
    // Answer one cycle after the read; unmapped addresses read as zero
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bus_rdata <= '0;
            bus_rvalid <= 1'b0;
        end else begin
            bus_rvalid <= bus_read;
            bus_rdata <= '0;
            if (pop) begin
                bus_rdata[7:0] <= mem[rd_ptr];
                bus_rdata[ps2rp_pkg::VALID_BIT] <= 1'b1;
                bus_rdata[ps2rp_pkg::COUNT_LSB +: 16] <= 16'(count);
            end else if (bus_read && bus_addr == ps2rp_pkg::CONTROL_ADDR) begin
                bus_rdata[ps2rp_pkg::IRQ_EN_BIT] <= rx_irq_enable;
                bus_rdata[ps2rp_pkg::IRQ_PEND_BIT] <= rx_irq_pending;
                bus_rdata[ps2rp_pkg::CE_BIT] <= cmd_error;
            end
        end
    end
endmodule : ps2rp_port

//--- tb/ps2rp_props.sv
// Checker for the PS/2 port: bus answer timing, fields, command start.
// Assumes it is bound to ps2rp_port and sees only that module's ports.
`timescale 1ns/100ps
module ps2rp_props #(
    parameter int unsigned INHIBIT_CYCLES = ps2rp_pkg::INHIBIT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [31:0] bus_addr,
    input wire logic bus_read,
    input wire logic bus_write,
    input wire logic [31:0] bus_wdata,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_rvalid,
    input wire logic irq,
    input wire logic ps2_clk_in,
    input wire logic ps2_clk_out,
    input wire logic ps2_clk_oe,
    input wire logic ps2_dat_in,
    input wire logic ps2_dat_out,
    input wire logic ps2_dat_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Length of the present clock-low stretch; a counter, since it is long
    int unsigned hold_cnt;
    always_ff @(posedge ref_clk) begin
        if (srst || !ps2_clk_oe) begin
            hold_cnt <= 0;
        end else begin
            hold_cnt <= hold_cnt + 1;
        end
    end
    sequence s_rd_ctrl;
        bus_rvalid && $past(bus_addr) == ps2rp_pkg::CONTROL_ADDR;
    endsequence
    sequence s_rd_empty;
        bus_rvalid && $past(bus_addr) == ps2rp_pkg::DATA_ADDR &&
            !bus_rdata[15];
    endsequence
    sequence s_start_bit;
        ps2_dat_oe && hold_cnt == INHIBIT_CYCLES;
    endsequence
    a_rd_answer: assert property (bus_read |=> bus_rvalid)
        else $error("read not answered one cycle later");
    a_no_spur_ans: assert property (!bus_read |=> !bus_rvalid)
        else $error("answer without a read");
    a_idle_rdata: assert property (!bus_rvalid |-> bus_rdata == 32'h0)
        else $error("read data not zero outside an answer");
    a_count_nonzero: assert property (bus_rvalid && bus_rdata[15] |->
        bus_rdata[31:16] != 16'h0)
        else $error("valid byte reported with zero count");
    a_empty_zero: assert property (s_rd_empty |-> bus_rdata == 32'h0)
        else $error("empty data read not all zero");
    a_pend_irq: assert property (s_rd_ctrl |->
        bus_rdata[8] == $past(irq))
        else $error("pending flag differs from interrupt");
    a_irq_gate: assert property ((s_rd_ctrl and !bus_rdata[0]) |->
        !$past(irq))
        else $error("interrupt raised while disabled");
    a_inhibit_len: assert property ($fell(ps2_clk_oe) |-> s_start_bit)
        else $error("clock hold length or start bit wrong");
    a_open_drain: assert property (!ps2_clk_out && !ps2_dat_out)
        else $error("open-drain outputs not low");
endmodule : ps2rp_props

bind ps2rp_port ps2rp_props #(.INHIBIT_CYCLES(INHIBIT_CYCLES)) u_props (
    .ref_clk, .srst, .bus_addr, .bus_read, .bus_write, .bus_wdata,
    .bus_rdata, .bus_rvalid, .irq, .ps2_clk_in, .ps2_clk_out,
    .ps2_clk_oe, .ps2_dat_in, .ps2_dat_out, .ps2_dat_oe
);

//--- tb/ps2rp_dev_model.sv
// Behavioural PS/2 keyboard: sends frames, takes host commands.
// Assumes open-drain wires resolved by the bench; 1 means released.
`timescale 1ns/100ps
module ps2rp_dev_model (
    input wire logic clk_w,
    input wire logic dat_w,
    input wire logic nack,
    output logic dev_clk,
    output logic dev_dat,
    output logic [8:0] rx_frame,
    output logic [7:0] rx_cnt
);
    logic busy = 1'b0;
    // Lines released; the clock stands still between frames
    initial begin
        dev_clk = 1'b1;
        dev_dat = 1'b1;
        rx_frame = 9'h0;
        rx_cnt = 8'h0;
    end
    // Start, data LSB first, odd parity, stop; 125 ns link clock
    task automatic send(input logic [7:0] b);
        logic [10:0] f;
        f = {1'b1, ~^b, b, 1'b0};
        busy = 1'b1;
        for (int i = 0; i < 11; i++) begin
            dev_dat = f[i];
            #31 dev_clk = 1'b0;
            #62.5 dev_clk = 1'b1;
            #31.5;
        end
        dev_dat = 1'b1;
        busy = 1'b0;
    endtask : send
    // Start bit after the hold: clock in 9 bits, then ack unless told not
    always @(negedge dat_w) begin
        #1;
        if (clk_w === 1'b1 && !busy) begin
            #50;
            for (int k = 0; k < 11; k++) begin
                if (k == 10) dev_dat = nack;
                dev_clk = 1'b0;
                #62.5 dev_clk = 1'b1;
                if (k < 9) rx_frame = {dat_w, rx_frame[8:1]};
                #62.5;
            end
            dev_dat = 1'b1;
            rx_cnt = rx_cnt + 8'h1;
        end
    end
endmodule : ps2rp_dev_model

//--- tb/ps2rp_port_tb_top.sv
// Bench for the PS/2 port: register reads and writes, frames both ways.
// Assumes the device model and the bound checker are compiled with it.
`timescale 1ns/100ps
module ps2rp_port_tb_top;
    localparam int unsigned DEPTH = 4;
    localparam logic [31:0] DA = ps2rp_pkg::DATA_ADDR;
    localparam logic [31:0] CA = ps2rp_pkg::CONTROL_ADDR;
    logic ref_clk = 1'b0, srst = 1'b1, bus_read = 1'b0, bus_write = 1'b0;
    logic [31:0] bus_addr = 32'h0, bus_wdata = 32'h0, bus_rdata, d;
    logic bus_rvalid, irq, ps2_clk_oe, ps2_dat_oe, dev_clk, dev_dat;
    logic nack = 1'b0;
    logic [8:0] rx_frame;
    logic [7:0] rx_cnt, old;
    int fail_count = 0, check_count = 0;
    // Open-drain resolution with pull-ups
    wire logic clk_w = ps2_clk_oe ? 1'b0 : dev_clk;
    wire logic dat_w = ps2_dat_oe ? 1'b0 : dev_dat;
    always #2.5 ref_clk = ~ref_clk;
    ps2rp_port #(.DEPTH(DEPTH), .INHIBIT_CYCLES(20), .TIMEOUT_CYCLES(2000))
        uut (.ref_clk, .srst, .bus_addr, .bus_read, .bus_write, .bus_wdata,
        .bus_rdata, .bus_rvalid, .irq, .ps2_clk_in(clk_w), .ps2_clk_out(),
        .ps2_clk_oe, .ps2_dat_in(dat_w), .ps2_dat_out(), .ps2_dat_oe);
    ps2rp_dev_model dev (.clk_w, .dat_w, .nack, .dev_clk, .dev_dat,
        .rx_frame, .rx_cnt);
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One-cycle strobe; the answer stands in the following cycle
    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        @(negedge ref_clk) {bus_addr, bus_read} = {a, 1'b1};
        @(negedge ref_clk) bus_read = 1'b0;
        q = bus_rvalid ? bus_rdata : 32'hdeadbeef;
    endtask : rd
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(negedge ref_clk) {bus_addr, bus_wdata, bus_write} = {a, v, 1'b1};
        @(negedge ref_clk) bus_write = 1'b0;
    endtask : wr
    function automatic logic [31:0] fd(input int n, input logic [7:0] b);
        return {n[15:0], 1'b1, 7'h0, b};
    endfunction : fd
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd(CA, d); chk(d, 32'h0);
        rd(DA, d); chk(d, 32'h0);
        rd(32'h10000108, d); chk(d, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_rx;
        int i;
        wr(CA, 32'h1);
        dev.send(8'ha5);
        dev.send(8'h3c);
        for (i = 0; i < 100 && irq !== 1'b1; i++) @(negedge ref_clk);
        if (i == 100) begin
            fail_count++;
            stop_test();
        end
        rd(CA, d); chk(d, 32'h101);
        rd(DA, d); chk(d, fd(2, 8'ha5));
        rd(CA, d); chk(d, 32'h101);
        rd(DA, d); chk(d, fd(1, 8'h3c));
        rd(CA, d); chk(d, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(CA, 32'h0);
        $display("test receive done");
    endtask : t_rx
    task automatic t_full;
        for (int i = 0; i <= DEPTH; i++) dev.send(8'h10 + i[7:0]);
        for (int i = 0; i < DEPTH; i++) begin
            rd(DA, d); chk(d, fd(DEPTH - i, 8'h10 + i[7:0]));
        end
        rd(DA, d); chk(d, 32'h0);
        $display("test full queue done");
    endtask : t_full
    task automatic t_tx;
        int i;
        logic [7:0] b;
        for (int n = 0; n < 2; n++) begin
            b = n ? 8'h81 : 8'h5a;
            nack = n[0];
            old = rx_cnt;
            wr(DA, {24'h0, b});
            for (i = 0; i < 1000 && rx_cnt == old; i++) @(negedge ref_clk);
            if (i == 1000) begin
                fail_count++;
                stop_test();
            end
            chk({23'h0, rx_frame}, {23'h0, ~^b, b});
            rd(CA, d); chk(d, n ? 32'h400 : 32'h0);
        end
        nack = 1'b0;
        wr(CA, 32'h400);
        rd(CA, d); chk(d, 32'h0);
        // A silent device must not hang the sender: the send phase times out
        dev.busy = 1'b1;
        wr(DA, 32'h5a);
        repeat (1000) @(negedge ref_clk);
        chk({31'h0, ps2_dat_oe}, 32'h1);
        repeat (1100) @(negedge ref_clk);
        chk({31'h0, ps2_dat_oe}, 32'h0);
        rd(CA, d); chk(d, 32'h400);
        dev.busy = 1'b0;
        wr(CA, 32'h400);
        $display("test command done");
    endtask : t_tx
    // Main sequence: reset for 12 cycles, then each scenario in turn
    initial begin
        repeat (12) @(negedge ref_clk);
        srst = 1'b0;
        t_reset();
        t_rx();
        t_full();
        t_tx();
        stop_test();
    end
endmodule : ps2rp_port_tb_top
